/* File: rtl/tbdl_defines.vh */
// register map, field positions, reset values and timing counts of the button logic
`ifndef TBDL_DEFINES_VH
`define TBDL_DEFINES_VH

`define TBDL_NUM_SENSE 12
`define TBDL_TICK_W 12

`define TBDL_ADDR_THR0 8'h13
`define TBDL_ADDR_THR11 8'h1e
`define TBDL_ADDR_CFG 8'h22
`define TBDL_ADDR_AVG 8'h23
`define TBDL_ADDR_NEG 8'h24
`define TBDL_ADDR_NEGCNT 8'h25
`define TBDL_ADDR_HYST 8'h26
`define TBDL_ADDR_STUCK 8'h27
`define TBDL_ADDR_STAT_LO 8'h28
`define TBDL_ADDR_STAT_HI 8'h29

`define TBDL_RST_CFG 8'h30
`define TBDL_RST_AVG 8'h50
`define TBDL_RST_NEG 8'ha0
`define TBDL_RST_NEGCNT 8'h01
`define TBDL_RST_HYST 8'h0a
`define TBDL_RST_STUCK 8'h00
`define TBDL_RST_THR 8'h00

`define TBDL_CFG_SCHEME 7
`define TBDL_CFG_PK_EN 6
`define TBDL_CFG_EVT_HI 5
`define TBDL_CFG_EVT_LO 4
`define TBDL_CFG_RDEB_HI 3
`define TBDL_CFG_RDEB_LO 2
`define TBDL_CFG_TDEB_HI 1
`define TBDL_CFG_TDEB_LO 0

`define TBDL_PK_PROX 4'd10
`define TBDL_PK_NOPROX 4'd11
`define TBDL_SAT_MIN 4'd3
`define TBDL_PCT_DIV 18'd100

// one second of the 10 MHz system clock
`define TBDL_SEC_CYCLES 24'h98_9680

`endif

/* File: rtl/tbdl_debounce.v */
// one sensor input: hysteresis compare, touch/release debounce and stuck-touch timer
`timescale 1ns/100ps
`include "tbdl_defines.vh"
module tbdl_debounce (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset_n,
	// rate enables
	input wire i_scan,
	input wire i_sec,
	// sample and settings
	input wire [11:0] i_ticks,
	input wire [7:0] i_thr,
	input wire [7:0] i_hyst,
	input wire [1:0] i_tdeb,
	input wire [1:0] i_rdeb,
	input wire [7:0] i_timeout,
	input wire i_grant,
	// state and events
	output wire o_ready,
	output reg o_touched,
	output reg o_touch_ev,
	output reg o_release_ev,
	output reg o_stuck_ev
);
	wire [9:0] thr4 = {i_thr, 2'b00};
	wire [17:0] prod = {8'h00, thr4} * {10'h000, i_hyst};
	wire [17:0] hyst_full = prod / `TBDL_PCT_DIV;
	wire [10:0] hyst = hyst_full[10:0];
	wire [12:0] up = {3'b000, thr4} + {2'b00, hyst};
	wire [12:0] dn = {3'b000, thr4} - {2'b00, hyst};
	wire signed [12:0] ticks_s = {i_ticks[11], i_ticks};
	wire touch_c = ticks_s > $signed(up);
	wire release_c = ticks_s < $signed(dn);
	wire [2:0] need_t = (i_tdeb == 2'b00) ? 3'd1 : {1'b0, i_tdeb} + 3'd1;
	wire [2:0] need_r = (i_rdeb == 2'b00) ? 3'd1 : {1'b0, i_rdeb} + 3'd1;
	reg [1:0] cnt;
	reg stuck;
	reg [7:0] secs;
	wire [2:0] cnt_p1 = {1'b0, cnt} + 3'd1;
	wire expire = i_sec && o_touched && (i_timeout != 8'h00) && (secs + 8'd1 >= i_timeout);

	assign o_ready = !o_touched && !stuck && touch_c && (cnt_p1 >= need_t);

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_touched <= 1'b0;
			o_touch_ev <= 1'b0;
			o_release_ev <= 1'b0;
			o_stuck_ev <= 1'b0;
			cnt <= 2'b00;
			stuck <= 1'b0;
			secs <= 8'h00;
		end else begin
			o_touch_ev <= 1'b0;
			o_release_ev <= 1'b0;
			o_stuck_ev <= 1'b0;
			if (expire) begin
				// forced release; a new touch waits for the real release first
				o_touched <= 1'b0;
				o_release_ev <= 1'b1;
				o_stuck_ev <= 1'b1;
				stuck <= 1'b1;
				cnt <= 2'b00;
				secs <= 8'h00;
			end else begin
				if (i_sec && o_touched && i_timeout != 8'h00)
					secs <= secs + 8'd1;
				if (i_scan) begin
					if (o_touched) begin
						if (release_c) begin
							if (cnt_p1 >= need_r) begin
								o_touched <= 1'b0;
								o_release_ev <= 1'b1;
								cnt <= 2'b00;
								secs <= 8'h00;
							end else
								cnt <= cnt_p1[1:0];
						end else
							cnt <= 2'b00;
					end else if (stuck) begin
						if (release_c)
							stuck <= 1'b0;
					end else if (touch_c) begin
						if (o_ready && i_grant) begin
							o_touched <= 1'b1;
							o_touch_ev <= 1'b1;
							cnt <= 2'b00;
							secs <= 8'h00;
						end else if (!o_ready)
							cnt <= cnt_p1[1:0];
					end else
						cnt <= 2'b00;
				end
			end
		end
	end
endmodule // tbdl_debounce

/* File: rtl/tbdl_top.v */
// button decision logic: registers, reporting scheme, events and compensation triggers
// How it works
// - scheme 0 reports priority key plus one matrix key; scheme 1 one key only.
// - priority key enable picks input ten with proximity on, else input eleven.
// - event field gates interrupt: none, touch, release, both; both by default.
// - release debounce: direct, two, three or four samples.
// - touch debounce: none, two, three or four samples; none by default.
// - averaging suspended while ticks exceed four times the suspend register.
// - negative threshold is register times four ticks, default 640.
// - negative count limit 1 to 255; zero reserved; default one.
// - count samples below negative threshold; reaching limit requests compensation.
// - one hysteresis percentage for all buttons, default ten percent.
// - touch when ticks exceed threshold plus threshold times hysteresis.
// - release when ticks drop below threshold minus threshold times hysteresis.
// - debounce counts qualifying samples, one per scan period.
// - stuck timeout forces compensation and release; retouch after real release.
// - three or more sensors above suspend threshold request compensation.
// - each input has its own threshold register, scaled by four.
`timescale 1ns/100ps
`include "tbdl_defines.vh"
module tbdl_top #(
	parameter [23:0] P_SEC_CYCLES = `TBDL_SEC_CYCLES
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset_n,
	// byte register port
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [7:0] o_reg_rdata,
	// sensing front end
	input wire i_scan_tick,
	input wire [143:0] i_ticks,
	input wire i_prox_enable,
	// results
	output wire [11:0] o_touch_status,
	output reg [11:0] o_avg_suspend,
	output reg o_comp_request,
	output reg o_interrupt_out_n
);
	localparam NS = `TBDL_NUM_SENSE;

	reg [7:0] button_config;
	reg [7:0] averaging_suspend_threshold;
	reg [7:0] negative_comp_threshold;
	reg [7:0] negative_count_limit;
	reg [7:0] button_hysteresis;
	reg [7:0] stuck_touch_timeout;
	reg [7:0] thr [0:NS-1];
	integer k;

	wire thr_hit = (i_reg_addr >= `TBDL_ADDR_THR0) && (i_reg_addr <= `TBDL_ADDR_THR11);
	wire [7:0] thr_off = i_reg_addr - `TBDL_ADDR_THR0;
	wire [3:0] thr_idx = thr_off[3:0];

	// register writes
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			button_config <= `TBDL_RST_CFG;
			averaging_suspend_threshold <= `TBDL_RST_AVG;
			negative_comp_threshold <= `TBDL_RST_NEG;
			negative_count_limit <= `TBDL_RST_NEGCNT;
			button_hysteresis <= `TBDL_RST_HYST;
			stuck_touch_timeout <= `TBDL_RST_STUCK;
			for (k = 0; k < NS; k = k + 1)
				thr[k] <= `TBDL_RST_THR;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`TBDL_ADDR_CFG: button_config <= i_reg_wdata;
				`TBDL_ADDR_AVG: averaging_suspend_threshold <= i_reg_wdata;
				`TBDL_ADDR_NEG: negative_comp_threshold <= i_reg_wdata;
				`TBDL_ADDR_NEGCNT: negative_count_limit <= i_reg_wdata;
				`TBDL_ADDR_HYST: button_hysteresis <= i_reg_wdata;
				`TBDL_ADDR_STUCK: stuck_touch_timeout <= i_reg_wdata;
				default: begin
					if (thr_hit)
						thr[thr_idx] <= i_reg_wdata;
				end
			endcase
		end
	end

	wire scheme_single = button_config[`TBDL_CFG_SCHEME];
	wire pk_en = button_config[`TBDL_CFG_PK_EN];
	wire [1:0] evt_sel = button_config[`TBDL_CFG_EVT_HI:`TBDL_CFG_EVT_LO];
	wire [1:0] rdeb = button_config[`TBDL_CFG_RDEB_HI:`TBDL_CFG_RDEB_LO];
	wire [1:0] tdeb = button_config[`TBDL_CFG_TDEB_HI:`TBDL_CFG_TDEB_LO];
	wire [3:0] pk_idx = i_prox_enable ? `TBDL_PK_PROX : `TBDL_PK_NOPROX;

	// one-second enable for the stuck timer
	reg [23:0] sec_cnt;
	reg sec_tick;
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sec_cnt <= 24'h00_0000;
			sec_tick <= 1'b0;
		end else if (sec_cnt >= P_SEC_CYCLES - 24'h00_0001) begin
			sec_cnt <= 24'h00_0000;
			sec_tick <= 1'b1;
		end else begin
			sec_cnt <= sec_cnt + 24'h00_0001;
			sec_tick <= 1'b0;
		end
	end

	wire [NS-1:0] ready;
	wire [NS-1:0] touch_ev;
	wire [NS-1:0] release_ev;
	wire [NS-1:0] stuck_ev;
	reg [NS-1:0] grant;

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_sense
			tbdl_debounce u_deb (
				.i_clk_sys(i_clk_sys),
				.i_reset_n(i_reset_n),
				.i_scan(i_scan_tick),
				.i_sec(sec_tick),
				.i_ticks(i_ticks[g*12 +: 12]),
				.i_thr(thr[g]),
				.i_hyst(button_hysteresis),
				.i_tdeb(tdeb),
				.i_rdeb(rdeb),
				.i_timeout(stuck_touch_timeout),
				.i_grant(grant[g]),
				.o_ready(ready[g]),
				.o_touched(o_touch_status[g]),
				.o_touch_ev(touch_ev[g]),
				.o_release_ev(release_ev[g]),
				.o_stuck_ev(stuck_ev[g])
			);
		end
	endgenerate

	// reporting scheme: lowest index wins among keys confirming in one scan; in scheme 0 the priority key is granted as well
	reg any_busy;
	reg mk_busy;
	reg is_pk;
	integer i;
	always @* begin
		grant = {NS{1'b0}};
		any_busy = |o_touch_status;
		mk_busy = 1'b0;
		is_pk = 1'b0;
		for (i = 0; i < NS; i = i + 1) begin
			if (o_touch_status[i] && !(pk_en && i == pk_idx))
				mk_busy = 1'b1;
		end
		for (i = 0; i < NS; i = i + 1) begin
			is_pk = pk_en && (i == pk_idx);
			if (scheme_single) begin
				if (ready[i] && !any_busy) begin
					grant[i] = 1'b1;
					any_busy = 1'b1;
				end
			end else if (is_pk) begin
				grant[i] = ready[i];
			end else if (ready[i] && !mk_busy) begin
				grant[i] = 1'b1;
				mk_busy = 1'b1;
			end
		end
	end

	// averaging suspend and saturation count
	wire [12:0] avg_lim = {3'b000, averaging_suspend_threshold, 2'b00};
	wire [12:0] neg_mag = {3'b000, negative_comp_threshold, 2'b00};
	wire signed [12:0] neg_lim = -$signed(neg_mag);
	reg [NS-1:0] next_avg;
	reg neg_any;
	reg [3:0] sat_num;
	integer j;
	always @* begin
		next_avg = {NS{1'b0}};
		neg_any = 1'b0;
		sat_num = 4'h0;
		for (j = 0; j < NS; j = j + 1) begin
			next_avg[j] = $signed({i_ticks[j*12+11], i_ticks[j*12 +: 12]}) > $signed(avg_lim);
			if ($signed({i_ticks[j*12+11], i_ticks[j*12 +: 12]}) < neg_lim)
				neg_any = 1'b1;
			if (next_avg[j])
				sat_num = sat_num + 4'h1;
		end
	end

	// compensation triggers
	reg [7:0] neg_cnt;
	reg sat_prev;
	wire [8:0] neg_p1 = {1'b0, neg_cnt} + 9'h001;
	wire neg_fire = i_scan_tick && neg_any && (neg_p1 >= {1'b0, negative_count_limit});
	wire sat_now = sat_num >= `TBDL_SAT_MIN;
	wire sat_fire = i_scan_tick && sat_now && !sat_prev;
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			neg_cnt <= 8'h00;
			sat_prev <= 1'b0;
			o_avg_suspend <= 12'h000;
			o_comp_request <= 1'b0;
		end else begin
			if (i_scan_tick) begin
				o_avg_suspend <= next_avg;
				sat_prev <= sat_now;
				if (!neg_any || neg_fire)
					neg_cnt <= 8'h00;
				else
					neg_cnt <= neg_p1[7:0];
			end
			o_comp_request <= neg_fire || sat_fire || (|stuck_ev);
		end
	end

	// interrupt: held low until the low status byte is read; a new event beats the clear
	wire evt_hit = (evt_sel[0] && |touch_ev) || (evt_sel[1] && |release_ev);
	wire irq_clr = i_reg_rd && (i_reg_addr == `TBDL_ADDR_STAT_LO);
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			o_interrupt_out_n <= 1'b1;
		else if (evt_hit)
			o_interrupt_out_n <= 1'b0;
		else if (irq_clr)
			o_interrupt_out_n <= 1'b1;
	end

	// register reads
	reg [7:0] next_rdata;
	always @* begin
		next_rdata = 8'h00;
		case (i_reg_addr)
			`TBDL_ADDR_CFG: next_rdata = button_config;
			`TBDL_ADDR_AVG: next_rdata = averaging_suspend_threshold;
			`TBDL_ADDR_NEG: next_rdata = negative_comp_threshold;
			`TBDL_ADDR_NEGCNT: next_rdata = negative_count_limit;
			`TBDL_ADDR_HYST: next_rdata = button_hysteresis;
			`TBDL_ADDR_STUCK: next_rdata = stuck_touch_timeout;
			`TBDL_ADDR_STAT_LO: next_rdata = o_touch_status[7:0];
			`TBDL_ADDR_STAT_HI: next_rdata = {4'h0, o_touch_status[11:8]};
			default: begin
				if (thr_hit)
					next_rdata = thr[thr_idx];
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= next_rdata;
	end
endmodule // tbdl_top

/* File: dv/tbdl_properties.sv */
// port assertions for the button decision logic
`timescale 1ns/100ps
module tbdl_properties (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset_n,
	// register port
	input wire [7:0] i_reg_addr,
	input wire i_reg_rd,
	input wire [7:0] o_reg_rdata,
	// sensing and results
	input wire i_scan_tick,
	input wire [11:0] o_touch_status,
	input wire [11:0] o_avg_suspend,
	input wire o_comp_request,
	input wire o_interrupt_out_n
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	// off a scan only a stuck expiry may move the status, and it asks for compensation
	a_status_on_scan: assert property ($changed(o_touch_status) && !$past(i_scan_tick)
		|=> o_comp_request)
		else $error("status moved off a scan without compensation");
	a_suspend_on_scan: assert property ($changed(o_avg_suspend) |-> $past(i_scan_tick))
		else $error("suspend moved off a scan");
	a_comp_on_scan: assert property (o_comp_request
		|-> $past(i_scan_tick) || $past(o_touch_status, 2) != $past(o_touch_status))
		else $error("compensation with no cause");
	a_sat_comp: assert property ($countones(o_avg_suspend) >= 3
		&& $countones($past(o_avg_suspend)) < 3 |-> o_comp_request)
		else $error("no compensation on saturation");
	a_irq_cause: assert property ($fell(o_interrupt_out_n)
		|-> $past(o_touch_status) != $past(o_touch_status, 2))
		else $error("interrupt without event");
	// a scan event landing in the read cycle wins, so that case is left out
	a_irq_clear: assert property (i_reg_rd && i_reg_addr == 8'h28 && !$past(i_scan_tick)
		|=> o_interrupt_out_n)
		else $error("interrupt not cleared");
	a_status_lo: assert property (i_reg_rd && i_reg_addr == 8'h28
		|=> o_reg_rdata == $past(o_touch_status[7:0]))
		else $error("status low byte wrong");
	a_status_hi: assert property (i_reg_rd && i_reg_addr == 8'h29
		|=> o_reg_rdata == {4'h0, $past(o_touch_status[11:8])})
		else $error("status high byte wrong");
endmodule // tbdl_properties

bind tbdl_top tbdl_properties u_props (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_rd,
	.o_reg_rdata, .i_scan_tick, .o_touch_status, .o_avg_suspend, .o_comp_request,
	.o_interrupt_out_n);

/* File: dv/tbdl_host.sv */
// host model: byte register accesses driven on falling edges
`timescale 1ns/100ps
module tbdl_host (
	// clock
	input wire i_clk_sys,
	// register port
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_reg_wr,
	output logic o_reg_rd,
	input wire [7:0] i_reg_rdata
);
	initial begin
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
	end

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		// the reserved count limit is never sent, the preferred one goes instead
		if (a == 8'h25 && d == 8'h00) d = 8'h01;
		@(negedge i_clk_sys);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(negedge i_clk_sys);
		o_reg_wr = 1'b0;
		// stale data is inverted so nothing can lean on it
		o_reg_wdata = ~d;
	endtask

	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk_sys);
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(negedge i_clk_sys);
		o_reg_rd = 1'b0;
		d = i_reg_rdata;
	endtask
endmodule // tbdl_host

/* File: dv/touch_button_decision_logic_test.sv */
// self-checking bench for the button decision logic
`timescale 1ns/100ps
module touch_button_decision_logic_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scan_tick = 1'b0;
	logic prox = 1'b0;
	logic [143:0] ticks = '0;
	wire [7:0] addr, wdata, rdata;
	wire wr, rd;
	wire [11:0] status, avg;
	wire comp, irq_n;
	logic [7:0] v;
	int errors = 0;
	int check_count = 0;

	always #50 clk = ~clk;

	tbdl_host u_host (.i_clk_sys(clk), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr),
		.o_reg_rd(rd), .i_reg_rdata(rdata));
	tbdl_top #(.P_SEC_CYCLES(24'h00_0014)) u_dut (.i_clk_sys(clk), .i_reset_n(rst_n),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_scan_tick(scan_tick), .i_ticks(ticks), .i_prox_enable(prox), .o_touch_status(status),
		.o_avg_suspend(avg), .o_comp_request(comp), .o_interrupt_out_n(irq_n));

	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [143:0] tk(input logic [11:0] m, input logic [11:0] hi,
		input logic [11:0] lo);
		logic [143:0] t;
		for (int n = 0; n < 12; n++) t[n*12 +: 12] = m[n] ? hi : lo;
		return t;
	endfunction

	task automatic scan(input logic [143:0] t);
		@(negedge clk);
		ticks = t;
		scan_tick = 1'b1;
		@(negedge clk);
		scan_tick = 1'b0;
	endtask

	task automatic t_regs;
		logic [7:0] a [8] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h00};
		logic [7:0] e [8] = '{8'h30, 8'h50, 8'ha0, 8'h01, 8'h0a, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			u_host.read(a[i], v);
			chk("reset value", 12'(v), 12'(e[i]));
		end
		u_host.write(8'h26, 8'h64);
		u_host.read(8'h26, v);
		chk("hysteresis", 12'(v), 12'h064);
		u_host.write(8'h26, 8'h0a);
	endtask

	task automatic t_events;
		for (int e = 0; e < 4; e++) begin
			u_host.write(8'h22, {2'b00, 2'(e), 4'h0});
			scan(tk(12'h008, 12'h001, 12'hfff));
			@(negedge clk);
			chk("irq on touch", 12'(irq_n), 12'(e % 2 == 0));
			u_host.read(8'h28, v);
			chk("status byte", 12'(v), 12'h008);
			scan(tk(12'h000, 12'h001, 12'hfff));
			@(negedge clk);
			chk("irq on release", 12'(irq_n), 12'(e < 2));
			u_host.read(8'h28, v);
		end
	endtask

	task automatic t_keys;
		logic [7:0] cfg [4] = '{8'h70, 8'hf0, 8'h70, 8'h30};
		logic [11:0] exp [4] = '{12'h808, 12'h008, 12'h408, 12'h008};
		for (int k = 0; k < 4; k++) begin
			u_host.write(8'h22, cfg[k]);
			prox = (k == 2);
			scan(tk(12'hc28, 12'h001, 12'hfff));
			chk("reported keys", status, exp[k]);
			scan(tk(12'h000, 12'h001, 12'hfff));
			chk("released keys", status, 12'h000);
		end
	endtask

	task automatic t_debounce;
		logic [11:0] s [9] = '{12'h06e, 12'h06e, 12'h06f, 12'h064, 12'h06f, 12'h06f, 12'h05a,
			12'h059, 12'h059};
		logic [8:0] hit = 9'h0e0;
		// threshold 100 ticks with ten percent: touch above 110, release below 90
		u_host.write(8'h16, 8'h19);
		u_host.write(8'h22, 8'h35);
		for (int i = 0; i < 9; i++) begin
			scan(tk(12'h008, s[i], 12'hfff));
			chk("debounced", status, {8'h00, hit[i], 3'h0});
		end
		// three-sample touch with four-sample release, then the other way round
		for (int c = 0; c < 2; c++) begin
			u_host.write(8'h22, c == 0 ? 8'h3e : 8'h3b);
			for (int n = 1; n <= 3 + c; n++) begin
				scan(tk(12'h008, 12'h06f, 12'hfff));
				chk("touch count", status, {8'h00, n == 3 + c, 3'h0});
			end
			for (int n = 1; n <= 4 - c; n++) begin
				scan(tk(12'h008, 12'h059, 12'hfff));
				chk("release count", status, {8'h00, n < 4 - c, 3'h0});
			end
		end
	endtask

	task automatic sc(input logic [143:0] t, input logic c, input logic [11:0] a);
		scan(t);
		chk("compensation", 12'(comp), 12'(c));
		chk("suspend", avg, a);
	endtask

	task automatic t_comp;
		sc(tk(12'h001, 12'hd44, 12'h000), 1'b1, 12'h000);
		u_host.write(8'h25, 8'h03);
		sc(tk(12'h001, 12'hd80, 12'h000), 1'b0, 12'h000);
		for (int k = 0; k < 3; k++) sc(tk(12'h001, 12'hd44, 12'h000), k == 2, 12'h000);
		sc(tk(12'h003, 12'h141, 12'h140), 1'b0, 12'h003);
		sc(tk(12'h007, 12'h141, 12'h140), 1'b1, 12'h007);
	endtask

	task automatic t_stuck;
		// two-second timeout; a second is 20 cycles in this bench
		u_host.write(8'h22, 8'h30);
		scan(tk(12'h000, 12'h001, 12'hfff));
		u_host.write(8'h27, 8'h02);
		u_host.read(8'h28, v);
		scan(tk(12'h002, 12'h001, 12'h000));
		chk("held touch", status, 12'h002);
		u_host.read(8'h28, v);
		for (int n = 0; n < 60 && status[1]; n++) @(negedge clk);
		chk("stuck release", status, 12'h000);
		@(negedge clk);
		chk("stuck compensation", 12'(comp), 12'h001);
		chk("irq on stuck", 12'(irq_n), 12'h000);
		scan(tk(12'h002, 12'h001, 12'h000));
		chk("no retouch", status, 12'h000);
		scan(tk(12'h002, 12'hfff, 12'h000));
		scan(tk(12'h002, 12'h001, 12'h000));
		chk("retouch", status, 12'h002);
		u_host.write(8'h27, 8'h00);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_regs();
		t_events();
		t_keys();
		t_debounce();
		t_comp();
		t_stuck();
		finish_test();
	end

	initial begin
		#5_000_000;
		errors++;
		finish_test();
	end
endmodule // touch_button_decision_logic_test
